//--- core/hub_recovery_pkg.sv
//
// Function
// R1 - sample the address pin within the sense time; set identifier and mode
// R2 - enable the I2C interface only after the init interval has elapsed
// R3 - software protects each of 16 blocks of 64 bytes individually
// R4 - protection bypass works only in offline mode, blocked in application
// R5 - forward host bus traffic onto the local bus for targets behind the hub
// R6 - bus clear recovery is honoured only in I2C mode
// R7 - host never attempts bus clear on a target in I3C mode
// R8 - host clears with 18 clock pulses, data undriven, then a STOP
// R9 - release data within 18 pulses, go idle, accept a new START
// R10 - bus reset whenever host clock stays low for the maximum timeout
// R11 - no bus reset for clock low shorter than the minimum timeout
// R12 - bus reset acts the same in both modes; hub and local targets together
// R13 - bus reset discards interface state and pending commands
// R14 - bus reset keeps registers except listed fields; back to I2C mode
// R15 - bus reset clears status field to 000, control bit 0, field 00
// R16 - bus reset does not resample the address pin; identifier kept
// R17 - bus reset floats host data and drives local data high
// R18 - bus reset counts as a STOP condition
// R19 - local data pullup: on-die when config bit is 0, board when 1
// R20 - push-pull drive only in I3C mode, open drain otherwise; code drives local data high in either mode on bus reset
// R21 - accepting the enter-I3C command sets the I3C status bit
// R22 - bus address is a four-bit type prefix then the three identifier bits
// R23 - host clock low time counted on the core clock, restarted on rise
// R24 - interface held in reset until power-on reset and init interval end
package hub_recovery_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ        = 20000;
  localparam int PIN_SENSE_US   = 5000;
  localparam int INIT_US        = 10000;
  localparam int TIMEOUT_MIN_US = 10000;
  localparam int TIMEOUT_MAX_US = 50000;
  // longest times and the init time round down, the least timeout rounds up
  localparam int SENSE_CYC   = PIN_SENSE_US * CLK_KHZ / 1000;
  localparam int INIT_CYC    = INIT_US * CLK_KHZ / 1000;
  localparam int TIMEOUT_CYC = (TIMEOUT_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int CNT_W       = 24;

  // ----------------------------------------------------------------------
  // bus clear and bus reset
  // ----------------------------------------------------------------------
  localparam int         CLEAR_PULSES  = 18;
  localparam logic [4:0] CLEAR_RELEASE = 5'h11;
  localparam logic [2:0] PULL_HIGH_CYC = 3'h4;

  // ----------------------------------------------------------------------
  // fields, reset values
  // ----------------------------------------------------------------------
  localparam int          NUM_BLOCKS     = 16;
  localparam int          BLOCK_BYTES    = 64;
  localparam int          STATUS_I3C_BIT = 0;
  localparam logic [2:0]  STATUS_RST     = 3'h0;
  localparam logic        IRQ_BIT_RST    = 1'h0;
  localparam logic [1:0]  ERR_CTL_RST    = 2'h0;
  localparam logic [15:0] PROT_RST       = 16'h0000;
  localparam logic [2:0]  HOST_ID_RST    = 3'h0;

  typedef enum logic [1:0] {
    PWR_POR   = 2'b00,
    PWR_SENSE = 2'b01,
    PWR_INIT  = 2'b11,
    PWR_READY = 2'b10
  } pwr_state_t;

endpackage

//--- core/low_time_counter.sv
`timescale 1ns/1ns
`default_nettype none
module low_time_counter #(
  parameter int LIMIT = hub_recovery_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // watched line
  input  wire logic lineLow,
  input  wire logic armed,
  // one pulse per over-long low period
  output logic      expired
);

  typedef struct packed {
    logic [hub_recovery_pkg::CNT_W-1:0] cnt;
    logic                               fired;
    logic                               pulse;
  } tmo_state_t;

  localparam logic [hub_recovery_pkg::CNT_W-1:0] LAST =
    hub_recovery_pkg::CNT_W'(LIMIT - 1);

  tmo_state_t st_r;
  tmo_state_t st_nxt;

  // low time counter, restarted whenever the line goes high
  always_comb begin
    st_nxt       = st_r;
    st_nxt.pulse = 1'b0;
    if (!lineLow || !armed) begin
      st_nxt.cnt   = '0; // see R23
      st_nxt.fired = 1'b0;
    end else if (!st_r.fired) begin
      if (st_r.cnt == LAST) begin
        st_nxt.fired = 1'b1; // see R10
        st_nxt.pulse = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1; // see R11
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired = st_r.pulse;

endmodule
`default_nettype wire

//--- core/hub_power_up_bus_recovery.sv
`timescale 1ns/1ns
`default_nettype none
module hub_power_up_bus_recovery #(
  parameter int        SENSE_CYC   = hub_recovery_pkg::SENSE_CYC,
  parameter int        INIT_CYC    = hub_recovery_pkg::INIT_CYC,
  parameter int        TIMEOUT_CYC = hub_recovery_pkg::TIMEOUT_CYC,
  // device type prefix; value is arbitrary
  parameter logic[3:0] DEV_TYPE_ID = 4'h5
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // address select pin, as sensed
  input  wire logic [2:0]  addrSelectPin,
  input  wire logic        addrSelectGnd,
  // host bus pins
  input  wire logic        hostClockIn,
  input  wire logic        hostDataIn,
  output logic             hostDataOut,
  output logic             hostDataOe_n,
  // local bus pins
  output logic             localClockOut,
  input  wire logic        localDataIn,
  output logic             localDataOut,
  output logic             localDataOe_n,
  output logic             localPullupEn,
  // protocol engine side
  input  wire logic        coreHostDrive,
  input  wire logic        coreHostData,
  input  wire logic        fwdActive,
  input  wire logic        fwdToLocal,
  input  wire logic        enterI3cCmd,
  output logic             ifaceReset,
  output logic             busIdle,
  output logic             stopEvent,
  output logic             busResetEvent,
  // identity
  output logic [6:0]       hubAddress,
  output logic [2:0]       hostIdentifier,
  output logic             offlineMode,
  output logic             ready,
  // configuration and status fields
  input  wire logic        statusWr,
  input  wire logic [2:0]  statusWrData,
  input  wire logic        irqCfgWr,
  input  wire logic        irqCfgWrData,
  input  wire logic        errCtlWr,
  input  wire logic [1:0]  errCtlWrData,
  input  wire logic        localPullupExt,
  output logic [2:0]       deviceStatus,
  output logic             irqConfigBit,
  output logic [1:0]       errorControl,
  output logic             i3cMode,
  output logic             pushPullEn,
  // block write protection
  input  wire logic        protWr,
  input  wire logic [3:0]  protBlock,
  input  wire logic        protSet,
  input  wire logic        protBypass,
  input  wire logic        memWrReq,
  input  wire logic [3:0]  memWrBlock,
  output logic             memWrGrant,
  output logic [15:0]      blockProtect
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  localparam int CW = hub_recovery_pkg::CNT_W;
  localparam logic [CW-1:0] SENSE_LAST = CW'(SENSE_CYC - 1);
  localparam logic [CW-1:0] INIT_LAST  = CW'(INIT_CYC - 1);

  typedef struct packed {
    hub_recovery_pkg::pwr_state_t pwr;
    logic [CW-1:0] cnt;
    logic [2:0]    hostId;
    logic          offline;
    logic [2:0]    status;
    logic          irqBit;
    logic [1:0]    err;
    logic [15:0]   prot;
    logic          clkPrev;
    logic          datPrev;
    logic [4:0]    clrCnt;
    logic          clrHold;
    logic          idle;
    logic          busRst;
    logic          stop;
    logic [2:0]    pullHigh;
    logic          hostOut;
    logic          hostOe_n;
    logic          locOut;
    logic          locOe_n;
    logic          locClk;
  } hub_state_t;

  localparam hub_state_t RST = '{
    pwr:      hub_recovery_pkg::PWR_POR,
    cnt:      '0,
    hostId:   hub_recovery_pkg::HOST_ID_RST,
    offline:  1'b0,
    status:   hub_recovery_pkg::STATUS_RST,
    irqBit:   hub_recovery_pkg::IRQ_BIT_RST,
    err:      hub_recovery_pkg::ERR_CTL_RST,
    prot:     hub_recovery_pkg::PROT_RST,
    clkPrev:  1'b1,
    datPrev:  1'b1,
    clrCnt:   5'h00,
    clrHold:  1'b0,
    idle:     1'b1,
    busRst:   1'b0,
    stop:     1'b0,
    pullHigh: 3'h0,
    hostOut:  1'b0,
    hostOe_n: 1'b1,
    locOut:   1'b0,
    locOe_n:  1'b1,
    locClk:   1'b1
  };

  hub_state_t s_r;
  hub_state_t s_nxt;
  logic       timeoutHit;
  logic       isReady;
  logic       inI3c;
  logic       startDet;
  logic       stopDet;
  logic       clkRise;
  logic       coreHoldsLow;

  // ----------------------------------------------------------------------
  // host clock low timeout
  // ----------------------------------------------------------------------
  low_time_counter #(
    .LIMIT   (TIMEOUT_CYC)
  ) u_timeout (
    .clk     (clk),
    .arst_n  (arst_n),
    .lineLow (~hostClockIn),
    .armed   (isReady),
    .expired (timeoutHit)
  );

  // ----------------------------------------------------------------------
  // bus condition decode
  // ----------------------------------------------------------------------
  assign isReady      = (s_r.pwr == hub_recovery_pkg::PWR_READY);
  assign inI3c        = s_r.status[hub_recovery_pkg::STATUS_I3C_BIT];
  assign clkRise      = hostClockIn && !s_r.clkPrev;
  assign startDet     = hostClockIn && s_r.clkPrev &&
                        s_r.datPrev && !hostDataIn;
  assign stopDet      = hostClockIn && s_r.clkPrev &&
                        !s_r.datPrev && hostDataIn;
  assign coreHoldsLow = coreHostDrive && !coreHostData;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt         = s_r;
    s_nxt.clkPrev = hostClockIn;
    s_nxt.datPrev = hostDataIn;
    s_nxt.busRst  = 1'b0;
    s_nxt.stop    = 1'b0;

    // power-up sequence
    unique case (s_r.pwr)
      hub_recovery_pkg::PWR_POR: begin
        s_nxt.pwr = hub_recovery_pkg::PWR_SENSE;
        s_nxt.cnt = '0;
      end
      hub_recovery_pkg::PWR_SENSE: begin
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (s_r.cnt >= SENSE_LAST) begin
          s_nxt.hostId  = addrSelectGnd ? 3'h0 : addrSelectPin; // see R1
          s_nxt.offline = addrSelectGnd; // see R1
          s_nxt.pwr     = hub_recovery_pkg::PWR_INIT;
        end
      end
      hub_recovery_pkg::PWR_INIT: begin
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (s_r.cnt >= INIT_LAST) begin
          s_nxt.pwr = hub_recovery_pkg::PWR_READY; // see R2
        end
      end
      hub_recovery_pkg::PWR_READY: begin
        s_nxt.cnt = s_r.cnt;
      end
    endcase

    // field writes from software, hardware set applied after
    if (isReady && statusWr) begin
      s_nxt.status = statusWrData;
    end
    if (isReady && irqCfgWr) begin
      s_nxt.irqBit = irqCfgWrData;
    end
    if (isReady && errCtlWr) begin
      s_nxt.err = errCtlWrData;
    end
    if (isReady && enterI3cCmd) begin
      s_nxt.status[hub_recovery_pkg::STATUS_I3C_BIT] = 1'b1; // see R21
    end

    // per-block write protection
    if (isReady && protWr) begin
      s_nxt.prot[protBlock] = protSet; // see R3
    end

    // bus clear: count pulses while this end holds data low in I2C mode
    if (!isReady || inI3c || !coreHoldsLow || s_r.clrHold) begin
      s_nxt.clrCnt = 5'h00; // see R6
    end else if (clkRise) begin
      s_nxt.clrCnt = s_r.clrCnt + 5'h01;
      if (s_r.clrCnt + 5'h01 >= hub_recovery_pkg::CLEAR_RELEASE) begin
        s_nxt.clrHold = 1'b1; // see R9
        s_nxt.idle    = 1'b1;
      end
    end

    // start leaves idle, stop returns to it
    if (isReady && startDet) begin
      s_nxt.idle    = 1'b0;
      s_nxt.clrHold = 1'b0; // see R9
    end
    if (isReady && stopDet) begin
      s_nxt.idle    = 1'b1;
      s_nxt.clrHold = 1'b0;
      s_nxt.stop    = 1'b1;
    end

    // local pull-high stretch after bus reset
    if (s_r.pullHigh != 3'h0) begin
      s_nxt.pullHigh = s_r.pullHigh - 3'h1;
    end

    // bus reset overrides everything pending
    if (timeoutHit) begin
      s_nxt.busRst   = 1'b1; // see R12
      s_nxt.stop     = 1'b1; // see R18
      s_nxt.idle     = 1'b1; // see R13
      s_nxt.clrHold  = 1'b0;
      s_nxt.clrCnt   = 5'h00;
      s_nxt.status   = hub_recovery_pkg::STATUS_RST; // see R14, R15
      s_nxt.irqBit   = hub_recovery_pkg::IRQ_BIT_RST; // see R15
      s_nxt.err      = hub_recovery_pkg::ERR_CTL_RST; // see R15
      s_nxt.pullHigh = hub_recovery_pkg::PULL_HIGH_CYC; // see R17
      s_nxt.hostId   = s_r.hostId; // see R16
      s_nxt.prot     = s_r.prot;
    end

    // host data pin
    s_nxt.hostOut  = 1'b0;
    s_nxt.hostOe_n = 1'b1;
    if (!isReady || s_r.clrHold || timeoutHit || s_r.busRst) begin
      s_nxt.hostOe_n = 1'b1; // see R24, R17
    end else if (inI3c && coreHostDrive) begin
      s_nxt.hostOut  = coreHostData; // see R20
      s_nxt.hostOe_n = 1'b0;
    end else if (coreHoldsLow ||
                 (fwdActive && !fwdToLocal && !localDataIn)) begin
      s_nxt.hostOe_n = 1'b0; // see R20, R5
    end

    // local data pin
    s_nxt.locOut  = 1'b0;
    s_nxt.locOe_n = 1'b1;
    if (timeoutHit || s_r.pullHigh != 3'h0) begin
      s_nxt.locOut  = 1'b1; // see R17
      s_nxt.locOe_n = 1'b0;
    end else if (isReady && !s_r.clrHold && fwdActive && fwdToLocal) begin
      if (inI3c) begin
        s_nxt.locOut  = hostDataIn; // see R5, R20
        s_nxt.locOe_n = 1'b0;
      end else begin
        s_nxt.locOe_n = hostDataIn; // see R5, R20
      end
    end

    // local clock follows host clock while forwarding
    s_nxt.locClk = (isReady && fwdActive && !timeoutHit) ?
                   hostClockIn : 1'b1; // see R5, R12
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // interface held while powering up, clearing or resetting
  assign ifaceReset    = !isReady || s_r.busRst || s_r.clrHold; // see R24
  assign ready         = isReady; // see R2
  assign busIdle       = s_r.idle;
  assign stopEvent     = s_r.stop;
  assign busResetEvent = s_r.busRst;

  // pins
  assign hostDataOut   = s_r.hostOut;
  assign hostDataOe_n  = s_r.hostOe_n;
  assign localDataOut  = s_r.locOut;
  assign localDataOe_n = s_r.locOe_n;
  assign localClockOut = s_r.locClk;
  assign localPullupEn = !localPullupExt; // see R19

  // identity
  assign hostIdentifier = s_r.hostId;
  assign hubAddress     = {DEV_TYPE_ID, s_r.hostId}; // see R22
  assign offlineMode    = s_r.offline;

  // fields
  assign deviceStatus = s_r.status;
  assign irqConfigBit = s_r.irqBit;
  assign errorControl = s_r.err;
  assign i3cMode      = inI3c;
  assign pushPullEn   = inI3c; // see R20
  assign blockProtect = s_r.prot;

  // write grant, bypass honoured only offline
  assign memWrGrant = memWrReq && isReady &&
                      (!s_r.prot[memWrBlock] ||
                       (protBypass && s_r.offline)); // see R4

endmodule
`default_nettype wire

//--- test/hub_recovery_sva.sv
`timescale 1ns/1ns
`default_nettype none
module hub_recovery_sva #(
  parameter int         INIT_CYC    = 20,
  parameter int         TIMEOUT_CYC = 16,
  parameter logic [3:0] DEV_TYPE_ID = 4'h3
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // pins
  input wire logic       hostClockIn,
  input wire logic       hostDataOut,
  input wire logic       hostDataOe_n,
  input wire logic       localDataOut,
  input wire logic       localDataOe_n,
  input wire logic       localPullupExt,
  input wire logic       localPullupEn,
  // events, identity, fields
  input wire logic       stopEvent,
  input wire logic       busResetEvent,
  input wire logic       ready,
  input wire logic [6:0] hubAddress,
  input wire logic [2:0] hostIdentifier,
  input wire logic [2:0] deviceStatus,
  input wire logic       irqConfigBit,
  input wire logic [1:0] errorControl,
  input wire logic       i3cMode,
  input wire logic       pushPullEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [7:0]  lowCnt_r;
  logic [15:0] upCnt_r;
  // -------------------------------------------------------------------
  // helper counts: host clock low run, cycles since reset release
  // -------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lowCnt_r <= 8'h00;
      upCnt_r  <= 16'h0000;
    end else begin
      lowCnt_r <= hostClockIn ? 8'h00 : lowCnt_r + {7'h00, lowCnt_r != 8'hFF};
      upCnt_r  <= upCnt_r + {15'h0000, upCnt_r != 16'hFFFF};
    end
  end
  property p_init; ready |-> upCnt_r >= INIT_CYC; endproperty
  a_init: assert property (p_init) else $error("ready too early");
  property p_pull; localPullupEn == !localPullupExt; endproperty
  a_pull: assert property (p_pull) else $error("pullup select");
  property p_pp; pushPullEn == i3cMode && i3cMode == deviceStatus[0];
  endproperty
  a_pp: assert property (p_pp) else $error("push-pull outside i3c");
  property p_od; !$past(i3cMode) && !hostDataOe_n |-> !hostDataOut;
  endproperty
  a_od: assert property (p_od) else $error("host driven high in i2c");
  property p_addr; hubAddress == {DEV_TYPE_ID, hostIdentifier}; endproperty
  a_addr: assert property (p_addr) else $error("hub address");
  property p_clr;
    busResetEvent |-> deviceStatus == 3'h0 && !irqConfigBit &&
      errorControl == 2'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("fields not cleared");
  property p_stop; busResetEvent |-> stopEvent && $stable(hostIdentifier);
  endproperty
  a_stop: assert property (p_stop) else $error("reset not a stop");
  property p_pins;
    busResetEvent |-> hostDataOe_n && !localDataOe_n && localDataOut;
  endproperty
  a_pins: assert property (p_pins) else $error("reset pin levels");
  property p_early; busResetEvent |-> $past(lowCnt_r, 3) >= TIMEOUT_CYC - 2;
  endproperty
  a_early: assert property (p_early) else $error("reset too soon");
  property p_late;
    ready && $past(ready, TIMEOUT_CYC + 1) && lowCnt_r == TIMEOUT_CYC
      |-> ##[0:3] busResetEvent;
  endproperty
  a_late: assert property (p_late) else $error("reset missing");
endmodule
bind hub_power_up_bus_recovery hub_recovery_sva #(
  .INIT_CYC(INIT_CYC), .TIMEOUT_CYC(TIMEOUT_CYC), .DEV_TYPE_ID(DEV_TYPE_ID)
) u_hub_recovery_sva (
  .clk, .arst_n, .hostClockIn, .hostDataOut, .hostDataOe_n, .localDataOut,
  .localDataOe_n, .localPullupExt, .localPullupEn, .stopEvent,
  .busResetEvent, .ready, .hubAddress, .hostIdentifier, .deviceStatus,
  .irqConfigBit, .errorControl, .i3cMode, .pushPullEn
);
`default_nettype wire

//--- test/host_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
  // clock
  input  wire logic clk,
  // device drive of host data
  input  wire logic hostDataOut,
  input  wire logic hostDataOe_n,
  // wire levels
  output logic      hostClock,
  output logic      hostData
);
  logic sdaRel;
  // open-drain data, board pullup
  assign hostData = sdaRel & (hostDataOe_n | hostDataOut);
  initial begin
    hostClock = 1'b1;
    sdaRel    = 1'b1;
  end
  // wait n edges, then move off the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // set clock and data release, then let one edge pass
  task automatic setLines(input logic c, input logic d);
    hostClock = c;
    sdaRel    = d;
    step(1);
  endtask
  // clock pulses, data left undriven; only used in i2c mode
  task automatic pulses(input int n);
    repeat (n) begin
      hostClock = 1'b0;
      step(2);
      hostClock = 1'b1;
      step(2);
    end
  endtask
  // hold clock low, clock idles high again after
  task automatic holdLow(input int n);
    hostClock = 1'b0;
    step(n);
    hostClock = 1'b1;
    step(2);
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sdaRel = 1'b0;
    step(2);
    sdaRel = 1'b1;
    step(2);
  endtask
endmodule
`default_nettype wire

//--- test/hub_power_up_bus_recovery_test.sv
`timescale 1ns/1ns
`default_nettype none
module hub_power_up_bus_recovery_test;
  localparam int TMO = 16;
  typedef struct packed {
    logic [2:0] st; logic irq; logic [1:0] err; logic ext; logic pu;
  } row_t;
  row_t rows [4] = '{'{3'h6, 1'b1, 2'h3, 1'b0, 1'b1},
                     '{3'h4, 1'b0, 2'h1, 1'b1, 1'b0},
                     '{3'h2, 1'b1, 2'h2, 1'b0, 1'b1},
                     '{3'h6, 1'b1, 2'h3, 1'b1, 1'b0}};
  logic        clk, arst_n, addrSelectGnd, hostClockIn, hostDataIn;
  logic        hostDataOut, hostDataOe_n, localClockOut, localDataOut;
  logic        localDataOe_n, localPullupEn, coreHostDrive, coreHostData;
  logic        enterI3cCmd, ifaceReset, busIdle, stopEvent, busResetEvent;
  logic        offlineMode, ready, statusWr, irqCfgWr, irqCfgWrData;
  logic        errCtlWr, localPullupExt, irqConfigBit, i3cMode, pushPullEn;
  logic        protWr, protSet, protBypass, memWrReq, memWrGrant;
  logic        fwdActive, fwdToLocal, localTgtLow;
  logic [1:0]  errCtlWrData, errorControl;
  logic [2:0]  addrSelectPin, hostIdentifier, statusWrData, deviceStatus;
  logic [3:0]  protBlock, memWrBlock;
  logic [6:0]  hubAddress;
  logic [15:0] blockProtect;
  int          miscompares, checks_done, resets, n;
  // -------------------------------------------------------------------
  // design and host side; device type value is arbitrary
  // -------------------------------------------------------------------
  hub_power_up_bus_recovery #(.SENSE_CYC(8), .INIT_CYC(20),
    .TIMEOUT_CYC(TMO), .DEV_TYPE_ID(4'h3)) u_hub_power_up_bus_recovery (
    .clk, .arst_n, .addrSelectPin, .addrSelectGnd, .hostClockIn,
    .hostDataIn, .hostDataOut, .hostDataOe_n, .localClockOut,
    .localDataIn((localDataOe_n | localDataOut) & !localTgtLow),
    .localDataOut,
    .localDataOe_n, .localPullupEn, .coreHostDrive, .coreHostData,
    .fwdActive, .fwdToLocal, .enterI3cCmd, .ifaceReset,
    .busIdle, .stopEvent, .busResetEvent, .hubAddress, .hostIdentifier,
    .offlineMode, .ready, .statusWr, .statusWrData, .irqCfgWr,
    .irqCfgWrData, .errCtlWr, .errCtlWrData, .localPullupExt,
    .deviceStatus, .irqConfigBit, .errorControl, .i3cMode, .pushPullEn,
    .protWr, .protBlock, .protSet, .protBypass, .memWrReq, .memWrBlock,
    .memWrGrant, .blockProtect);
  host_bus_model u_host_bus_model (.clk, .hostDataOut, .hostDataOe_n,
    .hostClock(hostClockIn), .hostData(hostDataIn));
  // clock, event count, watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (busResetEvent === 1'b1) resets++;
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // release reset, count cycles until ready
  task automatic boot();
    arst_n = 1'b0;
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    statusWr = 1'b1;
    tick(1);
    statusWr = 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk(16'(n >= 19 && n < 100), 16'h1);
    chk(16'(deviceStatus), 16'h0);
  endtask
  task automatic protect(input logic [3:0] blk);
    protWr = 1'b1;
    protBlock = blk;
    protSet = 1'b1;
    tick(1);
    protWr = 1'b0;
  endtask
  task automatic finish_test();
    if (miscompares == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    {addrSelectGnd, coreHostDrive, coreHostData, enterI3cCmd} = 4'h0;
    {statusWr, irqCfgWr, irqCfgWrData, errCtlWr, localPullupExt} = 5'h00;
    {protWr, protSet, protBypass, memWrReq, errCtlWrData} = 6'h00;
    {protBlock, memWrBlock} = 8'h00;
    {fwdActive, fwdToLocal, localTgtLow} = 3'h0;
    {miscompares, checks_done, resets} = 96'h0;
    addrSelectPin = 3'h5;
    statusWrData = 3'h6;
    boot();
    chk(16'(hostIdentifier), 16'h5);
    chk(16'(hubAddress), 16'h1D);
    chk(16'(offlineMode), 16'h0);
    {statusWr, irqCfgWr, errCtlWr} = 3'h7;
    foreach (rows[i]) begin
      {statusWrData, irqCfgWrData, errCtlWrData} = rows[i][7:2];
      localPullupExt = rows[i].ext;
      tick(1);
      chk(16'({deviceStatus, irqConfigBit, errorControl}), 16'(rows[i][7:2]));
      chk(16'({localPullupEn, i3cMode}), 16'({rows[i].pu, 1'b0}));
    end
    {statusWr, irqCfgWr, errCtlWr} = 3'h0;
    // forwarding both ways, open drain in i2c mode
    {fwdActive, fwdToLocal} = 2'h3;
    u_host_bus_model.setLines(1'b0, 1'b0);
    chk(16'({localClockOut, localDataOe_n, localDataOut}), 16'h0);
    u_host_bus_model.setLines(1'b1, 1'b1);
    chk(16'({localClockOut, localDataOe_n}), 16'h3);
    {fwdToLocal, localTgtLow} = 2'h1;
    tick(1);
    chk(16'(hostDataOe_n), 16'h0);
    {fwdActive, localTgtLow} = 2'h0;
    tick(1);
    chk(16'({hostDataOe_n, localClockOut}), 16'h3);
    protect(4'h3);
    chk(blockProtect, 16'h0008);
    {memWrReq, protBypass, memWrBlock} = 6'h33;
    #1 chk(16'(memWrGrant), 16'h0);
    memWrBlock = 4'h4;
    #1 chk(16'(memWrGrant), 16'h1);
    {memWrReq, protBypass} = 2'h0;
    u_host_bus_model.holdLow(TMO - 4);
    chk(16'(resets), 16'h0);
    enterI3cCmd = 1'b1;
    tick(1);
    enterI3cCmd = 1'b0;
    chk(16'({deviceStatus, pushPullEn}), 16'hF);
    addrSelectPin = 3'h2;
    u_host_bus_model.holdLow(TMO + 6);
    chk(16'(resets), 16'h1);
    chk(16'({deviceStatus, irqConfigBit, errorControl, i3cMode}), 16'h0);
    chk(16'(hostIdentifier), 16'h5);
    chk(blockProtect, 16'h0008);
    coreHostDrive = 1'b1;
    u_host_bus_model.pulses(16);
    chk(16'(hostDataOe_n), 16'h0);
    u_host_bus_model.pulses(1);
    chk(16'({hostDataOe_n, busIdle, ifaceReset}), 16'h7);
    coreHostDrive = 1'b0; // engine lets go on interface reset
    tick(2);
    chk(16'({hostDataOe_n, busIdle}), 16'h3);
    u_host_bus_model.stop();
    chk(16'(busIdle), 16'h1);
    addrSelectGnd = 1'b1;
    boot();
    chk(16'({offlineMode, hostIdentifier}), 16'h8);
    protect(4'h3);
    {memWrReq, protBypass, memWrBlock} = 6'h33;
    #1 chk(16'(memWrGrant), 16'h1);
    finish_test();
  end
endmodule
`default_nettype wire
